// >>> verilog/ooc_output_ctrl.sv
// Purpose: output on/off and margin control behind the bus command port
// Assumes: command port and pins synchronous to clk
// Notes: one command per cmd_valid pulse, answer on the next cycle
module ooc_output_ctrl
(
	input  wire logic                          clk,
	input  wire logic                          sys_rst,
	input  wire logic                          cmd_valid,
	input  wire logic                          cmd_write,
	input  wire logic [7:0]                    cmd_code,
	input  wire logic [7:0]                    cmd_wdata,
	output logic                               rsp_valid,
	output logic                               rsp_ok,
	output logic [7:0]                         rsp_rdata,
	input  wire logic                          ctrl_pin,
	input  wire logic                          power_present,
	input  wire logic                          remote_control_setup_ok,
	input  wire logic                          ov_fault,
	input  wire logic                          uv_fault,
	input  wire logic                          ov_warn,
	input  wire logic                          uv_warn,
	output logic                               out_on,
	output logic                               out_fast_off,
	output logic                               out_ramp_down,
	output logic [1:0]                         margin_sel,
	output logic [ooc_pkg::FLT_BITS-1:0]       fault_status
);
	import ooc_pkg::*;

	localparam int CNT_W = 16;

	ooc_ctl_if c ();

	logic [7:0]  op_reg;
	logic [7:0]  op_next;
	logic [7:0]  cfg_reg;
	logic        wr_op;
	logic        wr_cfg;
	logic        clr_cmd;
	ooc_state_t  state_reg;
	ooc_state_t  state_next;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic        imm_off;

	assign c.op_byte                 = op_reg;
	assign c.cfg_byte                = cfg_reg;
	assign c.pin_level               = ctrl_pin;
	assign c.power_present           = power_present;
	assign c.remote_control_setup_ok = remote_control_setup_ok;
	assign c.clear_faults            = clr_cmd;
	assign c.flt_events              = {uv_warn, ov_warn, uv_fault, ov_fault};

	ooc_enable_decide u_decide
	(
		.c (c)
	);

	ooc_fault_track u_fault
	(
		.clk     (clk),
		.sys_rst (sys_rst),
		.c       (c)
	);

	always_comb
	begin
		wr_op   = 1'b0;
		wr_cfg  = 1'b0;
		clr_cmd = 1'b0;
		if (cmd_valid && cmd_write && cmd_code == CMD_OPERATION)
		begin
			wr_op = 1'b1;
		end
		else if (cmd_valid && cmd_write && cmd_code == CMD_ON_OFF_CFG)
		begin
			wr_cfg = 1'b1;
		end
		else if (cmd_valid && cmd_write && cmd_code == CMD_CLEAR_FAULTS)
		begin
			clr_cmd = 1'b1;
		end
	end

	// each field only takes a defined code
	always_comb
	begin
		op_next = op_reg;
		if (cmd_wdata[EN_HI:EN_LO] != 2'h3)
		begin
			op_next[EN_HI:EN_LO] = cmd_wdata[EN_HI:EN_LO];
		end
		if (cmd_wdata[MRG_HI:MRG_LO] != 2'h3)
		begin
			op_next[MRG_HI:MRG_LO] = cmd_wdata[MRG_HI:MRG_LO];
		end
		if (cmd_wdata[FLT_HI:FLT_LO] == FLT_ACT || cmd_wdata[FLT_HI:FLT_LO] == FLT_IGNORE)
		begin
			op_next[FLT_HI:FLT_LO] = cmd_wdata[FLT_HI:FLT_LO];
		end
		op_next[1:0] = 2'h0;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			op_reg <= OP_RESET;
		end
		else if (wr_op)
		begin
			op_reg <= op_next;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cfg_reg <= CFG_RESET;
		end
		else if (wr_cfg)
		begin
			cfg_reg <= {3'h0, cmd_wdata[4:0]};
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rsp_valid <= 1'b0;
			rsp_ok    <= 1'b0;
			rsp_rdata <= 8'h00;
		end
		else
		begin
			rsp_valid <= cmd_valid;
			rsp_ok    <= 1'b0;
			rsp_rdata <= 8'h00;
			if (cmd_valid && cmd_code == CMD_OPERATION)
			begin
				rsp_ok    <= 1'b1;
				rsp_rdata <= cmd_write ? 8'h00 : op_reg;
			end
			else if (cmd_valid && cmd_code == CMD_ON_OFF_CFG)
			begin
				rsp_ok    <= 1'b1;
				rsp_rdata <= cmd_write ? 8'h00 : cfg_reg;
			end
			else if (cmd_valid && cmd_code == CMD_CLEAR_FAULTS)
			begin
				rsp_ok <= cmd_write;
			end
		end
	end

	// choose between fast and sequenced shutdown
	always_comb
	begin
		if (!power_present)
		begin
			imm_off = 1'b1;
		end
		else if (c.pin_cause)
		begin
			imm_off = c.pin_off_imm;
		end
		else if (cfg_reg[CFG_POWERUP] && cfg_reg[CFG_USE_BUS])
		begin
			imm_off = c.bus_off_imm;
		end
		else
		begin
			imm_off = 1'b0;
		end
	end

	always_comb
	begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			ST_OFF:
			begin
				if (c.run_req)
				begin
					state_next = ST_RUN;
				end
			end
			ST_RUN:
			begin
				if (!c.run_req && imm_off)
				begin
					state_next = ST_OFF;
				end
				else if (!c.run_req)
				begin
					state_next = ST_DELAY;
					cnt_next   = CNT_W'(OFF_DELAY_CYC - 1);
				end
			end
			ST_DELAY:
			begin
				if (imm_off && !c.run_req)
				begin
					state_next = ST_OFF;
				end
				else if (cnt_reg == '0)
				begin
					state_next = ST_FALL;
					cnt_next   = CNT_W'(FALL_TIME_CYC - 1);
				end
				else
				begin
					cnt_next = cnt_reg - 1'b1;
				end
			end
			ST_FALL:
			begin
				if ((imm_off && !c.run_req) || cnt_reg == '0)
				begin
					state_next = ST_OFF;
				end
				else
				begin
					cnt_next = cnt_reg - 1'b1;
				end
			end
			default:
			begin
				state_next = ST_OFF;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_reg <= ST_OFF;
			cnt_reg   <= '0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			out_on        <= 1'b0;
			out_ramp_down <= 1'b0;
			out_fast_off  <= 1'b0;
			margin_sel    <= MRG_NOM;
			fault_status  <= '0;
		end
		else
		begin
			out_on        <= (state_next == ST_RUN) || (state_next == ST_DELAY);
			out_ramp_down <= state_next == ST_FALL;
			out_fast_off  <= (state_reg != ST_OFF) && (state_next == ST_OFF) && imm_off;
			margin_sel    <= op_reg[MRG_HI:MRG_LO];
			fault_status  <= c.flt_status;
		end
	end
endmodule : ooc_output_ctrl

// >>> verilog/ooc_pkg.sv
// Purpose: constants for the output on/off and margin control block
// Assumes: command port carries bus command codes and data bytes
// Notes: timing counts derive from the 50 MHz clock
package ooc_pkg;
	localparam logic [7:0] CMD_OPERATION    = 8'h01;
	localparam logic [7:0] CMD_ON_OFF_CFG   = 8'h02;
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;

	localparam int EN_HI   = 7;
	localparam int EN_LO   = 6;
	localparam int MRG_HI  = 5;
	localparam int MRG_LO  = 4;
	localparam int FLT_HI  = 3;
	localparam int FLT_LO  = 2;

	localparam logic [1:0] EN_IMM_OFF  = 2'h0;
	localparam logic [1:0] EN_SOFT_OFF = 2'h1;
	localparam logic [1:0] EN_ON       = 2'h2;
	localparam logic [1:0] MRG_NOM     = 2'h0;
	localparam logic [1:0] MRG_LOW     = 2'h1;
	localparam logic [1:0] MRG_HIGH    = 2'h2;
	localparam logic [1:0] FLT_IGNORE  = 2'h1;
	localparam logic [1:0] FLT_ACT     = 2'h2;

	localparam int CFG_POWERUP  = 4;
	localparam int CFG_USE_BUS  = 3;
	localparam int CFG_USE_PIN  = 2;
	localparam int CFG_PIN_POL  = 1;
	localparam int CFG_PIN_IMM  = 0;

	localparam logic [7:0] OP_RESET  = 8'h08;
	localparam logic [7:0] CFG_RESET = 8'h1a;

	localparam int FLT_OV_FAULT = 0;
	localparam int FLT_UV_FAULT = 1;
	localparam int FLT_OV_WARN  = 2;
	localparam int FLT_UV_WARN  = 3;
	localparam int FLT_BITS     = 4;

	localparam int CLK_MHZ        = 50;
	localparam int OFF_DELAY_NS   = 1000;
	localparam int FALL_TIME_NS   = 2000;
	localparam int OFF_DELAY_CYC  = (OFF_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int FALL_TIME_CYC  = (FALL_TIME_NS * CLK_MHZ + 999) / 1000;

	typedef enum {ST_OFF, ST_RUN, ST_DELAY, ST_FALL} ooc_state_t;
endpackage : ooc_pkg

// >>> verilog/ooc_ctl_if.sv
// Purpose: carries settings and decisions between the control block parts
// Assumes: single clock domain
// Notes: none
interface ooc_ctl_if;
	import ooc_pkg::*;
	logic [7:0]          op_byte;
	logic [7:0]          cfg_byte;
	logic                pin_level;
	logic                power_present;
	logic                remote_control_setup_ok;
	logic                run_req;
	logic                pin_off_imm;
	logic                bus_off_imm;
	logic                pin_cause;
	logic                clear_faults;
	logic [FLT_BITS-1:0] flt_events;
	logic [FLT_BITS-1:0] flt_status;

	modport top
	(
		output op_byte, cfg_byte, pin_level, power_present, remote_control_setup_ok, clear_faults, flt_events,
		input  run_req, pin_off_imm, bus_off_imm, pin_cause, flt_status
	);
	modport decide
	(
		input  op_byte, cfg_byte, pin_level, power_present, remote_control_setup_ok,
		output run_req, pin_off_imm, bus_off_imm, pin_cause
	);
	modport fault
	(
		input  op_byte, clear_faults, flt_events,
		output flt_status
	);
endinterface : ooc_ctl_if

// >>> verilog/ooc_enable_decide.sv
// Purpose: decides from config, bus field and pin whether the output may run
// Assumes: pin level already synchronous
// Notes: purely combinational
module ooc_enable_decide
(
	ooc_ctl_if.decide c
);
	import ooc_pkg::*;
	logic pin_asserted;
	logic bus_ok;
	logic pin_ok;

	always_comb
	begin
		pin_asserted = c.cfg_byte[CFG_PIN_POL] ? c.pin_level : ~c.pin_level;
		bus_ok       = ~c.cfg_byte[CFG_USE_BUS] | (c.op_byte[EN_HI:EN_LO] == EN_ON);
		pin_ok       = ~c.cfg_byte[CFG_USE_PIN] | pin_asserted;
		if (!c.power_present)
		begin
			c.run_req = 1'b0;
		end
		else if (!c.cfg_byte[CFG_POWERUP])
		begin
			c.run_req = c.remote_control_setup_ok;
		end
		else
		begin
			c.run_req = bus_ok & pin_ok;
		end
		c.pin_cause   = c.cfg_byte[CFG_POWERUP] & ~pin_ok;
		c.pin_off_imm = c.cfg_byte[CFG_PIN_IMM];
		c.bus_off_imm = c.op_byte[EN_HI:EN_LO] == EN_IMM_OFF;
	end
endmodule : ooc_enable_decide

// >>> verilog/ooc_fault_track.sv
// Purpose: sticky over/under voltage fault and warning status
// Assumes: events are one-cycle pulses
// Notes: a new event beats a clear in the same cycle
module ooc_fault_track
(
	input wire logic  clk,
	input wire logic  sys_rst,
	ooc_ctl_if.fault  c
);
	import ooc_pkg::*;
	logic [FLT_BITS-1:0] status_reg;
	logic [FLT_BITS-1:0] status_next;
	logic                mask_events;

	always_comb
	begin
		// margined with ignore selected drops events
		mask_events = (c.op_byte[MRG_HI:MRG_LO] != MRG_NOM) && (c.op_byte[FLT_HI:FLT_LO] == FLT_IGNORE);
		status_next = c.clear_faults ? '0 : status_reg;
		if (!mask_events)
		begin
			status_next = status_next | c.flt_events;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			status_reg <= '0;
		end
		else
		begin
			status_reg <= status_next;
		end
	end

	assign c.flt_status = status_reg;
endmodule : ooc_fault_track

// >>> bench/ooc_props.sv
// Purpose: port checks for the on/off control block
// Assumes: one clock, synchronous reset
// Notes: shadows track bus writes to the setting bytes
module ooc_props
(
	input wire logic	clk,
	input wire logic	sys_rst,
	input wire logic	cmd_valid,
	input wire logic	cmd_write,
	input wire logic [7:0]	cmd_code,
	input wire logic [7:0]	cmd_wdata,
	input wire logic	rsp_valid,
	input wire logic	rsp_ok,
	input wire logic	ctrl_pin,
	input wire logic	power_present,
	input wire logic	ov_fault,
	input wire logic	uv_fault,
	input wire logic	ov_warn,
	input wire logic	uv_warn,
	input wire logic	out_on,
	input wire logic	out_fast_off,
	input wire logic	out_ramp_down,
	input wire logic [1:0]	margin_sel,
	input wire logic [ooc_pkg::FLT_BITS-1:0]	fault_status
);
	import ooc_pkg::*;
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	logic [7:0]	cfg_reg;
	logic [1:0]	en_reg;
	logic [7:0]	ramp_reg;
	logic	wr_op;
	logic	pin_off;
	assign wr_op = cmd_valid && cmd_write && cmd_code == CMD_OPERATION;
	// pin says stop, pin in use with fast style, bus not holding it off
	assign pin_off = cfg_reg[4] && cfg_reg[2] && cfg_reg[0] && ctrl_pin != cfg_reg[1]
		&& (!cfg_reg[3] || en_reg == EN_ON);
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			cfg_reg <= CFG_RESET;
		else if (cmd_valid && cmd_write && cmd_code == CMD_ON_OFF_CFG)
			cfg_reg <= cmd_wdata;
	end
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			en_reg <= OP_RESET[7:6];
		else if (wr_op && cmd_wdata[7:6] != 2'h3)
			en_reg <= cmd_wdata[7:6];
	end
	always_ff @(posedge clk)
	begin
		if (sys_rst || !out_ramp_down)
			ramp_reg <= 8'h00;
		else
			ramp_reg <= ramp_reg + 8'h01;
	end
	property p_bad_code;
		cmd_valid && !(cmd_code inside {[8'h01:8'h03]}) |=> rsp_valid && !rsp_ok;
	endproperty
	a_bad_code: assert property (p_bad_code) else $error("unknown code taken");
	property p_clear;
		cmd_valid && cmd_write && cmd_code == CMD_CLEAR_FAULTS
			&& !(ov_fault || uv_fault || ov_warn || uv_warn) |-> ##2 fault_status == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("faults not cleared");
	property p_margin;
		wr_op && cmd_wdata[5:4] != 2'h3 |-> ##2 margin_sel == $past(cmd_wdata[5:4], 2);
	endproperty
	a_margin: assert property (p_margin) else $error("margin not applied");
	property p_fast;
		out_fast_off |-> !out_on && !out_ramp_down ##1 !out_fast_off;
	endproperty
	a_fast: assert property (p_fast) else $error("fast off not clean");
	property p_power;
		!power_present |-> ##2 !out_on;
	endproperty
	a_power: assert property (p_power) else $error("runs without power");
	property p_bus_off;
		wr_op && cmd_wdata[7:6] == EN_IMM_OFF && cfg_reg[4] && cfg_reg[3] |-> ##3 !out_on && !out_ramp_down;
	endproperty
	a_bus_off: assert property (p_bus_off) else $error("bus off ignored");
	property p_pin_off;
		pin_off [*3] |-> !out_on && !out_ramp_down;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin off ignored");
	property p_ramp;
		$fell(out_ramp_down) && !out_fast_off |-> ramp_reg == 8'h64;
	endproperty
	a_ramp: assert property (p_ramp) else $error("fall time wrong");
	c_fast: cover property (out_fast_off);
	c_ramp: cover property ($fell(out_ramp_down));
	c_fault: cover property (fault_status != '0);
endmodule : ooc_props

bind ooc_output_ctrl ooc_props u_props (.*);

// >>> bench/ooc_host_model.sv
// Purpose: bus host and pin driver facing the control block
// Assumes: answer one cycle after a taken command
// Notes: released lines show inverted data
module ooc_host_model
(
	input wire logic	clk,
	input wire logic	rsp_valid,
	input wire logic	rsp_ok,
	input wire logic [7:0]	rsp_rdata,
	output logic	cmd_valid,
	output logic	cmd_write,
	output logic [7:0]	cmd_code,
	output logic [7:0]	cmd_wdata,
	output logic	ctrl_pin,
	output logic	power_present,
	output logic	remote_control_setup_ok
);
	initial
	begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 8'h00;
		ctrl_pin = 1'b0;
		power_present = 1'b1;
		remote_control_setup_ok = 1'b1;
	end
	task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d, output logic k,
		output logic [7:0] r);
		if (w && c == 8'h01 && d[3:2] inside {2'h0, 2'h3})
			d[3:2] = 2'h2;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_write <= w;
		cmd_code <= c;
		cmd_wdata <= d;
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_code <= ~c;
		cmd_wdata <= ~d;
		#1;
		k = rsp_valid ? rsp_ok : 1'bx;
		r = rsp_rdata;
	endtask : xfer
	task automatic pins(input logic p, input logic pw, input logic so);
		@(posedge clk);
		ctrl_pin <= p;
		power_present <= pw;
		remote_control_setup_ok <= so;
	endtask : pins
endmodule : ooc_host_model

// >>> bench/tb_top.sv
// Purpose: self-checking bench for the on/off control block
// Assumes: host model drives command port and pins
// Notes: fault traffic from a fixed xorshift seed
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ooc_pkg::*;
	logic	clk, sys_rst, cmd_valid, cmd_write, rsp_valid, rsp_ok, ok;
	logic	ctrl_pin, power_present, remote_control_setup_ok;
	logic	ov_fault, uv_fault, ov_warn, uv_warn, out_on, out_fast_off, out_ramp_down;
	logic [7:0]	cmd_code, cmd_wdata, rsp_rdata, rd;
	logic [1:0]	margin_sel, m;
	logic [3:0]	fault_status;
	logic [31:0]	seed;
	int	err_total, comparisons, cycles, n;
	logic [7:0]	codes[4] = '{8'h01, 8'h02, 8'h03, 8'h7f};
	logic [8:0]	reads[4] = '{9'h108, 9'h11a, 9'h000, 9'h000};
	logic [7:0]	cfgs[3] = '{8'h17, 8'h15, 8'h14};
	ooc_output_ctrl dut (.*);
	ooc_host_model host (.*);
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	function automatic logic [3:0] exp_flt(input logic [1:0] mg, input logic f, input logic [3:0] e);
		return (mg != MRG_NOM && !f) ? 4'h0 : e;
	endfunction : exp_flt
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		host.xfer(1'b1, c, d, ok, rd);
		chk(ok, 1'b1, "write ack");
	endtask : wr
	task automatic ramp_len(output int k);
		k = 0;
		while (!out_ramp_down && k < 100)
		begin
			cyc(1);
			k++;
		end
		k = 0;
		while (out_ramp_down && k < 200)
		begin
			cyc(1);
			k++;
		end
	endtask : ramp_len
	task automatic fast_seen(output int k);
		k = 0;
		repeat (4)
		begin
			cyc(1);
			k += out_fast_off;
		end
	endtask : fast_seen
	task automatic finish_test;
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_total++;
			finish_test();
		end
	end
	initial
	begin
		sys_rst = 1'b1;
		{uv_warn, ov_warn, uv_fault, ov_fault} = 4'h0;
		seed = 32'h6ea4f64a;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		cyc(1);
		chk({out_on, out_fast_off, out_ramp_down, margin_sel, fault_status}, 16'h0000, "reset out");
		for (int i = 0; i < 4; i++)
		begin
			host.xfer(1'b0, codes[i], 8'h00, ok, rd);
			chk({ok, rd}, reads[i], "read back");
		end
		// margin 11 is reserved and keeps the last margin
		for (int i = 0; i < 4; i++)
		begin
			wr(CMD_OPERATION, {EN_ON, i[1:0], FLT_ACT, 2'h0});
			cyc(3);
			chk({out_on, margin_sel}, {1'b1, i == 3 ? MRG_HIGH : i[1:0]}, "margin");
		end
		wr(CMD_OPERATION, {EN_SOFT_OFF, MRG_NOM, FLT_ACT, 2'h0});
		cyc(40);
		chk(out_on, 1'b1, "soft delay");
		ramp_len(n);
		chk(n, 100, "soft fall");
		wr(CMD_OPERATION, {EN_ON, MRG_NOM, FLT_ACT, 2'h0});
		cyc(3);
		wr(CMD_OPERATION, OP_RESET);
		fast_seen(n);
		chk({n[3:0], out_on}, 5'h02, "bus imm off");
		for (int i = 0; i < 3; i++)
		begin
			wr(CMD_ON_OFF_CFG, cfgs[i]);
			host.pins(cfgs[i][1], 1'b1, 1'b1);
			cyc(4);
			chk(out_on, 1'b1, "pin on");
			host.pins(!cfgs[i][1], 1'b1, 1'b1);
			if (cfgs[i][0])
				fast_seen(n);
			else
				ramp_len(n);
			chk({n, out_on}, {cfgs[i][0] ? 32'd1 : 32'd100, 1'b0}, "pin off");
		end
		wr(CMD_ON_OFF_CFG, 8'h1f);
		host.pins(1'b1, 1'b1, 1'b1);
		cyc(4);
		chk(out_on, 1'b0, "bus holds off");
		wr(CMD_OPERATION, {EN_ON, MRG_NOM, FLT_ACT, 2'h0});
		cyc(3);
		chk(out_on, 1'b1, "both on");
		wr(CMD_ON_OFF_CFG, 8'h00);
		wr(CMD_OPERATION, OP_RESET);
		host.pins(1'b0, 1'b1, 1'b1);
		cyc(4);
		chk(out_on, 1'b1, "always on");
		host.pins(1'b0, 1'b0, 1'b1);
		cyc(3);
		chk(out_on, 1'b0, "power lost");
		host.pins(1'b0, 1'b1, 1'b0);
		cyc(200);
		chk(out_on, 1'b0, "setup blocks");
		host.pins(1'b0, 1'b1, 1'b1);
		for (int i = 0; i < 24; i++)
		begin
			seed = xs(seed);
			m = seed[1:0] == 2'h3 ? MRG_LOW : seed[1:0];
			wr(CMD_OPERATION, {EN_ON, m, seed[2] ? FLT_ACT : FLT_IGNORE, 2'h0});
			wr(CMD_CLEAR_FAULTS, 8'h00);
			cyc(1);
			chk(fault_status, 4'h0, "clear");
			@(posedge clk);
			{uv_warn, ov_warn, uv_fault, ov_fault} <= seed[7:4];
			@(posedge clk);
			{uv_warn, ov_warn, uv_fault, ov_fault} <= 4'h0;
			cyc(2);
			chk(fault_status, exp_flt(m, seed[2], seed[7:4]), "faults");
		end
		finish_test();
	end
endmodule : tb_top
